/* File: rtl/dbs_burst_port.sv */
`timescale 1ns/1ps
// How it works
// - write: strobe low, select low, data t+1,t+2
// - read: words from C-bar t+1 to C t+3
// - powers up deselected, outputs tristated
// - burst low address bits wrap modulo four
// - write words taken on both input edges
// - read launched on clock edges alone; strap only drives out_ref_single
// - x18: two selects gate two 9-bit lanes
// - x36: four selects gate four 9-bit lanes
// - all selects high writes nothing
// - selects sampled separately per data word
// - same request on next K rise ignored
// - read after write returns newest data
module dbs_burst_port
    import dbs_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  clock_active,
    input  wire logic                  single_clock_strap,
    input  wire logic                  org_x18,
    input  wire logic                  load_strobe_n,
    input  wire logic                  read_write_sel,
    input  wire logic [DBS_ADDR_W-1:0] address,
    input  wire logic [DBS_LANES-1:0]  byte_write_select_n,
    input  wire logic [DBS_DATA_W-1:0] data_in,
    output logic      [DBS_DATA_W-1:0] data_out,
    output logic                       data_oe,
    output logic                       out_ref_single
);
    // ==========================================================
    // helpers
    function automatic logic [DBS_ADDR_W-1:0] burst_addr(
        input logic [DBS_ADDR_W-1:0] base,
        input logic [1:0]            idx
    );
        burst_addr = {base[DBS_ADDR_W-1:2], 2'(base[1:0] + idx)};
    endfunction : burst_addr

    function automatic logic [2:0] tmr_step(
        input logic [2:0] t,
        input logic [2:0] last
    );
        tmr_step = (t == DBS_TMR_IDLE || t == last) ? DBS_TMR_IDLE : 3'(t + 3'h1);
    endfunction : tmr_step

    // ==========================================================
    // state and decode
    dbs_state_t                 state_r;
    dbs_state_t                 state_nxt;
    logic [DBS_DATA_W-1:0]      mem [DBS_DEPTH];

    logic                       k_edge;
    logic                       rd_acc;
    logic                       wr_acc;
    logic                       launch;
    logic [1:0]                 launch_idx;
    logic [DBS_ADDR_W-1:0]      launch_addr;
    logic                       wr_en;
    logic [DBS_ADDR_W-1:0]      wr_addr;
    logic [DBS_LANES-1:0]       lane_we;
    logic [DBS_DATA_W-1:0]      rd_word;

    assign k_edge = clock_active && state_r.phase == DBS_PHASE_K;
    assign rd_acc = k_edge && !load_strobe_n && read_write_sel && !state_r.last_rd;
    assign wr_acc = k_edge && !load_strobe_n && !read_write_sel && !state_r.last_wr;

    always_comb begin
        launch      = 1'b0;
        launch_idx  = 2'h0;
        launch_addr = '0;
        wr_en       = 1'b0;
        wr_addr     = '0;
        for (int s = 0; s < DBS_SLOTS; s++) begin
            if (state_r.rd_tmr[s] >= DBS_RD_FIRST && state_r.rd_tmr[s] <= DBS_RD_LAST) begin
                launch      = clock_active;
                launch_idx  = 2'(state_r.rd_tmr[s] - DBS_RD_FIRST);
                launch_addr = burst_addr(state_r.rd_base[s], launch_idx);
            end
            if (state_r.wr_tmr[s] >= DBS_WR_FIRST && state_r.wr_tmr[s] <= DBS_WR_LAST) begin
                wr_en   = clock_active;
                wr_addr = burst_addr(state_r.wr_base[s],
                                     2'(state_r.wr_tmr[s] - DBS_WR_FIRST));
            end
        end
    end

    // per-word lane enables, x18 uses only the two low lanes
    always_comb begin
        for (int l = 0; l < DBS_LANES; l++) begin
            lane_we[l] = wr_en && !byte_write_select_n[l]
                         && (l < DBS_X18_LN || !org_x18);
        end
    end

    // array read with bypass from the word being written now
    always_comb begin
        rd_word = mem[launch_addr];
        for (int l = 0; l < DBS_LANES; l++) begin
            if (lane_we[l] && wr_addr == launch_addr) begin
                rd_word[l*DBS_LANE_W +: DBS_LANE_W] = data_in[l*DBS_LANE_W +: DBS_LANE_W];
            end
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        if (!state_r.strap_done) begin
            state_nxt.strap_done = 1'b1;
            state_nxt.single_clk = single_clock_strap;
        end
        if (clock_active) begin
            state_nxt.phase = !state_r.phase;
            if (k_edge) begin
                state_nxt.last_rd = rd_acc;
                state_nxt.last_wr = wr_acc;
            end
            for (int s = 0; s < DBS_SLOTS; s++) begin
                state_nxt.rd_tmr[s] = tmr_step(state_r.rd_tmr[s], DBS_RD_LAST);
                state_nxt.wr_tmr[s] = tmr_step(state_r.wr_tmr[s], DBS_WR_LAST);
            end
            if (rd_acc) begin
                if (state_r.rd_tmr[0] == DBS_TMR_IDLE) begin
                    state_nxt.rd_tmr[0]  = DBS_TMR_START;
                    state_nxt.rd_base[0] = address;
                end else begin
                    state_nxt.rd_tmr[1]  = DBS_TMR_START;
                    state_nxt.rd_base[1] = address;
                end
            end
            if (wr_acc) begin
                if (state_r.wr_tmr[0] == DBS_TMR_IDLE) begin
                    state_nxt.wr_tmr[0]  = DBS_TMR_START;
                    state_nxt.wr_base[0] = address;
                end else begin
                    state_nxt.wr_tmr[1]  = DBS_TMR_START;
                    state_nxt.wr_base[1] = address;
                end
            end
            state_nxt.oe = launch;
            if (launch) begin
                state_nxt.dout = rd_word;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_r            <= '0;
            state_r.dout       <= DBS_DOUT_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // array write, byte masked
    always_ff @(posedge clock) begin
        for (int l = 0; l < DBS_LANES; l++) begin
            if (!srst && lane_we[l]) begin
                mem[wr_addr][l*DBS_LANE_W +: DBS_LANE_W] <= data_in[l*DBS_LANE_W +: DBS_LANE_W];
            end
        end
    end

    assign data_out       = state_r.dout;
    assign data_oe        = state_r.oe;
    assign out_ref_single = state_r.single_clk;

    // ==========================================================
    // checks
    sequence s_rd_start;
        rd_acc ##1 clock_active [*3];
    endsequence

    sequence s_wr_start;
        wr_acc ##1 clock_active [*2];
    endsequence

    AST_READ_FIRST_WORD: assert property (@(posedge clock) disable iff (srst)
        s_rd_start |-> launch && launch_idx == 2'h0)
        else $error("read word not launched three half-cycles after command");

    AST_WRITE_FIRST_WORD: assert property (@(posedge clock) disable iff (srst)
        s_wr_start |-> wr_en && wr_addr == $past(address, 2))
        else $error("write word not taken two half-cycles after command");

    AST_POWER_UP_Z: assert property (@(posedge clock)
        $past(srst) |-> !data_oe)
        else $error("data driven right after reset");

    AST_NOP_Z: assert property (@(posedge clock) disable iff (srst)
        clock_active && !launch |=> !data_oe)
        else $error("bus driven with no read word launched");

    AST_CLOCK_STOP_HOLD: assert property (@(posedge clock) disable iff (srst)
        !clock_active |=> $stable(data_out) && $stable(data_oe))
        else $error("data pins changed while clocks stopped");

    AST_BURST_WRAP: assert property (@(posedge clock) disable iff (srst)
        launch && launch_idx != 2'h0 && $past(launch) && $past(clock_active)
        |-> launch_addr[1:0] == 2'($past(launch_addr[1:0]) + 2'h1))
        else $error("burst address did not step modulo four");

    AST_SECOND_READ_IGNORED: assert property (@(posedge clock) disable iff (srst)
        rd_acc ##1 clock_active [*2] |-> !rd_acc)
        else $error("read accepted on consecutive input clock rise");

    AST_ALL_MASKED: assert property (@(posedge clock) disable iff (srst)
        wr_en && (&byte_write_select_n) |-> lane_we == 4'h0)
        else $error("array written with all selects high");

    AST_X18_LANES: assert property (@(posedge clock) disable iff (srst)
        org_x18 |-> lane_we[3:2] == 2'h0)
        else $error("upper lanes written in x18 organisation");

    AST_FORWARD_NEWEST: assert property (@(posedge clock) disable iff (srst)
        launch && wr_en && wr_addr == launch_addr && lane_we == 4'hF
        |=> data_out == $past(data_in))
        else $error("read did not return data written the same cycle");
endmodule : dbs_burst_port

/* File: include/dbs_pkg.sv */
// ==========================================================
// burst port constants
package dbs_pkg;
    localparam int DBS_DATA_W  = 36;
    localparam int DBS_LANE_W  = 9;
    localparam int DBS_LANES   = 4;
    localparam int DBS_X18_LN  = 2;
    localparam int DBS_ADDR_W  = 8;
    localparam int DBS_DEPTH   = 256;
    localparam int DBS_SLOTS   = 2;

    // slot timer values, in half-cycles after the command edge
    localparam logic [2:0] DBS_TMR_IDLE  = 3'h0;
    localparam logic [2:0] DBS_TMR_START = 3'h1;
    localparam logic [2:0] DBS_WR_FIRST  = 3'h2;
    localparam logic [2:0] DBS_WR_LAST   = 3'h5;
    localparam logic [2:0] DBS_RD_FIRST  = 3'h3;
    localparam logic [2:0] DBS_RD_LAST   = 3'h6;

    localparam logic              DBS_PHASE_K  = 1'b0;
    localparam logic [DBS_DATA_W-1:0] DBS_DOUT_RST = 36'h0_0000_0000;

    typedef struct packed {
        logic                                 phase;
        logic                                 last_rd;
        logic                                 last_wr;
        logic                                 single_clk;
        logic                                 strap_done;
        logic [DBS_SLOTS-1:0][2:0]            rd_tmr;
        logic [DBS_SLOTS-1:0][DBS_ADDR_W-1:0] rd_base;
        logic [DBS_SLOTS-1:0][2:0]            wr_tmr;
        logic [DBS_SLOTS-1:0][DBS_ADDR_W-1:0] wr_base;
        logic [DBS_DATA_W-1:0]                dout;
        logic                                 oe;
    } dbs_state_t;
endpackage : dbs_pkg

/* File: test/dbs_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================
// controller model
module dbs_ctrl_model
    import dbs_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  clock_active,
    output logic                       load_strobe_n,
    output logic                       read_write_sel,
    output logic      [DBS_ADDR_W-1:0] address,
    output logic      [DBS_LANES-1:0]  byte_write_select_n,
    output logic      [DBS_DATA_W-1:0] data_in
);
    initial begin
        load_strobe_n = 1'b1;
        read_write_sel = 1'b0;
        address = '0;
        byte_write_select_n = 4'hF;
        data_in = '0;
    end

    // waits for an edge the device counts
    task automatic step();
        @(posedge clock);
        while (!clock_active) @(posedge clock);
    endtask : step

    task automatic cmd(input logic rd, input logic [DBS_ADDR_W-1:0] a, input int extra,
             input logic [3:0][DBS_DATA_W-1:0] d, input logic [3:0][DBS_LANES-1:0] s);
        step();
        load_strobe_n  <= 1'b0;
        read_write_sel <= rd;
        address        <= a;
        step();
        load_strobe_n  <= 1'b1;
        read_write_sel <= ~rd;
        address        <= ~a;
        for (int k = 0; k < 4 && !rd; k++) begin
            step();
            data_in             <= d[k];
            byte_write_select_n <= s[k];
        end
        if (!rd) begin
            step();
            data_in             <= ~d[3];
            byte_write_select_n <= ~s[3];
            step();
        end
        repeat (extra) step();
    endtask : cmd
endmodule : dbs_ctrl_model

/* File: test/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
// ==========================================
// top bench
module tb
    import dbs_pkg::*;
;
    logic                  clock, srst, clock_active, org_x18, strap, act_q;
    logic                  load_strobe_n, read_write_sel, data_oe, out_ref_single;
    logic [DBS_ADDR_W-1:0] address;
    logic [DBS_LANES-1:0]  byte_write_select_n;
    logic [DBS_DATA_W-1:0] data_in, data_out, held, got_w;
    logic [DBS_DATA_W-1:0] mem [DBS_DEPTH];
    logic [DBS_DATA_W-1:0] exp_q [$];
    logic [31:0]           seed = 32'h016D;
    int                    err_count, total_checks, cycles;

    dbs_burst_port i_dbs_burst_port (.clock, .srst, .clock_active, .single_clock_strap(strap),
        .org_x18, .load_strobe_n, .read_write_sel, .address, .byte_write_select_n, .data_in,
        .data_out, .data_oe, .out_ref_single);
    dbs_ctrl_model i_dbs_ctrl_model (.clock, .clock_active, .load_strobe_n, .read_write_sel,
        .address, .byte_write_select_n, .data_in);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // writes one burst and updates the shadow copy
    task wr(input logic [7:0] a, input logic x18, input logic masked);
        logic [3:0][DBS_DATA_W-1:0] d;
        logic [3:0][DBS_LANES-1:0]  s;
        logic [DBS_ADDR_W-1:0]      w;
        for (int k = 0; k < 4; k++) begin
            d[k] = DBS_DATA_W'({rnd(), rnd()});
            s[k] = !masked ? 4'h0 : (k == 3) ? 4'hF : DBS_LANES'(rnd());
            w = {a[7:2], a[1:0] + 2'(k)};
            for (int l = 0; l < (x18 ? DBS_X18_LN : DBS_LANES); l++)
                if (!s[k][l]) mem[w][l*DBS_LANE_W +: DBS_LANE_W] = d[k][l*DBS_LANE_W +: DBS_LANE_W];
        end
        org_x18 <= x18;
        i_dbs_ctrl_model.cmd(1'b0, a, 0, d, s);
    endtask : wr

    task rd(input logic [7:0] a, input int extra, input logic keep);
        for (int k = 0; k < 4; k++)
            if (keep) exp_q.push_back(mem[{a[7:2], a[1:0] + 2'(k)}]);
        org_x18 <= 1'b0;
        i_dbs_ctrl_model.cmd(1'b1, a, extra, '0, '0);
    endtask : rd

    always @(posedge clock) begin
        act_q <= clock_active;
        cycles++;
        if (cycles > 3000) begin
            err_count++;
            wrap_up();
        end
    end

    // ==========================================
    // output watcher
    always @(negedge clock) begin
        if (srst === 1'b0) begin
            if (!act_q) `CHK("frozen data", held, data_out)
            else if (data_oe !== 1'b0) begin
                if (exp_q.size() == 0) `CHK("idle enable", 1'b0, data_oe)
                else begin
                    got_w = exp_q.pop_front();
                    `CHK("read word", got_w, data_out)
                end
            end
        end
        held = data_out;
    end

    initial begin
        srst = 1'b1;
        clock_active = 1'b1;
        org_x18 = 1'b0;
        strap = 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        `CHK("enable after reset", 1'b0, data_oe)
        `CHK("data after reset", DBS_DOUT_RST, data_out)
        `CHK("single clock strap", 1'b1, out_ref_single)
        repeat (2) @(posedge clock);
        for (int b = 0; b < 12; b++) wr(8'(b * 4), 1'b0, 1'b0);
        for (int b = 0; b < 8; b++) wr(8'(b * 5), b[0], 1'b1);
        for (int b = 0; b < 12; b++) rd(8'(b * 4 + b % 4), 2, 1'b1);
        rd(8'h05, 0, 1'b1);
        rd(8'h09, 2, 1'b0);
        wr(8'h2B, 1'b0, 1'b1);
        rd(8'h2B, 2, 1'b1);
        fork
            wr(8'h2B, 1'b0, 1'b0);
            begin
                repeat (2) @(posedge clock);
                rd(8'h2A, 2, 1'b1);
            end
        join
        fork
            rd(8'h12, 2, 1'b1);
            begin
                repeat (5) @(posedge clock);
                clock_active <= 1'b0;
                repeat (3) @(posedge clock);
                clock_active <= 1'b1;
            end
        join
        repeat (12) @(posedge clock);
        srst  <= 1'b1;
        strap <= 1'b0;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        strap <= 1'b1;
        @(negedge clock);
        `CHK("enable after second reset", 1'b0, data_oe)
        `CHK("strap captured low", 1'b0, out_ref_single)
        repeat (4) @(negedge clock);
        `CHK("strap kept after capture", 1'b0, out_ref_single)
        `CHK("words left", 32'd0, 32'(exp_q.size()))
        wrap_up();
    end
endmodule : tb
